// file: rtl/pkdc_regs.svh
// register map, field positions, reset values and timing for the panel key/display controller
// assumes a 200 MHz ref_clk and a 32-bit apb slave port
`ifndef PKDC_REGS_SVH
`define PKDC_REGS_SVH
`define PKDC_ADDR_CTRL     12'h000
`define PKDC_ADDR_SEL      12'h004
`define PKDC_ADDR_STAT     12'h008
`define PKDC_ADDR_DISP     12'h00c
`define PKDC_ADDR_KEYS     12'h010
`define PKDC_ADDR_CMD      12'h014
`define PKDC_ADDR_EDIT     12'h018
// ctrl fields
`define PKDC_CTRL_HALT_EN  0
`define PKDC_CTRL_JOG_EN   1
`define PKDC_CTRL_DIR_EN   2
`define PKDC_CTRL_LOCAL    3
`define PKDC_CTRL_PROG_BLK 4
`define PKDC_CTRL_DIRPERM  5
`define PKDC_CTRL_UNIT_SEL 6
`define PKDC_CTRL_MODE_LO  8
`define PKDC_CTRL_MODE_HI  9
`define PKDC_CTRL_RST      32'h0000_0007
// sel fields
`define PKDC_SEL_ACT_LO    0
`define PKDC_SEL_ACT_HI    1
`define PKDC_SEL_PRG_LO    2
`define PKDC_SEL_PRG_HI    3
`define PKDC_SEL_VAR_LO    8
`define PKDC_SEL_VAR_HI    12
`define PKDC_VAR_MAX       5'd22
`define PKDC_GROUP_MAX     3'h6
// stat fields
`define PKDC_STAT_ALARM    0
`define PKDC_STAT_WARN     1
`define PKDC_STAT_TERMSTOP 2
// timing
`define PKDC_DEBOUNCE_NS   10000
`define PKDC_HOLD_NS       500000000
`define PKDC_FLASH_NS      250000000
`define PKDC_CLK_NS        5
`endif

// file: rtl/pkdc_pkg.sv
// types shared by the panel key/display controller
// assumes pkdc_regs.svh holds the register map, field and timing constants
package pkdc_pkg;
  typedef enum logic [2:0] {
    PKDC_RO1 = 3'b001,
    PKDC_RO2 = 3'b010,
    PKDC_RO3 = 3'b100
  } pkdc_ro_t;
  typedef enum logic [3:0] {
    PKDC_M_DISP  = 4'b0001,
    PKDC_M_QUICK = 4'b0010,
    PKDC_M_MENU  = 4'b0100,
    PKDC_M_EDIT  = 4'b1000
  } pkdc_mode_t;
  typedef enum logic [1:0] {
    PKDC_L3_BLANK = 2'h0,
    PKDC_L3_PARAM = 2'h1,
    PKDC_L3_GROUP = 2'h2
  } pkdc_l3_t;
endpackage

// file: rtl/pkdc_top.sv
// panel key/display controller: key decode, read-out states, menu modes, local run commands
// assumes synchronous key levels, apb master, parameter store reached through edit ports
//
// Overview of operation
// [RULE1] view key toggles read-out state 1 and 2
// [RULE2] hold view enters 3, release gives 2
// [RULE3] read-out state 1 after reset
// [RULE4] state 1 line 2 shows selected variable
// [RULE5] display mode shows four variables plus status
// [RULE6] line 2 shows measurement unless alarm/warning
// [RULE7] line 3 blank in operation, line 4 status/value
// [RULE8] view returns to display; menu keys swap menus
// [RULE9] edit opens change, confirm commits, cancel abandons
// [RULE10] plus/minus select or change; left/right group, cursor
// [RULE11] enabled halt stops or clears trip, flashes
// [RULE12] panel halt latched until panel start
// [RULE13] enabled jog forces preset while held; the code keeps jog off while halt_q is set
// [RULE14] direction toggles only local, enabled, permitted
// [RULE15] start releases halt, never overrides terminal stop
// [RULE16] local keys act local and remote, not direction
// [RULE17] programming allowed unless blocked
// [RULE18] active setup shown, programmed setup flashes
// [RULE19] alarm and warning lamps with status text
// [RULE20] variable selection and user unit or letter
// [RULE21] keys debounced and edge-detected
// [RULE22] view hold told apart by hold threshold
`timescale 1ns/1ps
`include "pkdc_regs.svh"
module pkdc_top #(
  parameter int DEB_CYC   = (`PKDC_DEBOUNCE_NS + `PKDC_CLK_NS - 1) / `PKDC_CLK_NS,
  parameter int HOLD_CYC  = (`PKDC_HOLD_NS + `PKDC_CLK_NS - 1) / `PKDC_CLK_NS,
  parameter int FLASH_CYC = `PKDC_FLASH_NS / `PKDC_CLK_NS,
  parameter int NKEYS     = 12
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // keypad levels, high while pressed
  input  wire logic [NKEYS-1:0] key_raw,
  // drive status
  input  wire logic        alarm_in,
  input  wire logic        warn_in,
  input  wire logic        term_stop,
  input  wire logic        power_ok,
  // drive commands
  output logic             halt_q,
  output logic             trip_clear,
  output logic             jog_active,
  output logic             dir_rev_q,
  output logic             commit_stb,
  output logic [31:0]      commit_val,
  output logic [7:0]       param_sel_q,
  output logic [2:0]       group_q,
  // display and lamps
  output pkdc_pkg::pkdc_ro_t   readout_q,
  output pkdc_pkg::pkdc_mode_t mode_q,
  output pkdc_pkg::pkdc_l3_t   line3_sel,
  output logic             line2_show,
  output logic             line2_flash,
  output logic             line4_value,
  output logic             unit_letter_u,
  output logic [4:0]       var_sel_q,
  output logic [2:0]       cursor_q,
  output logic [1:0]       setup_act,
  output logic [1:0]       setup_prg,
  output logic             setup_prg_show,
  output logic             setup_prg_blink,
  output logic             lamp_alarm,
  output logic             lamp_warn,
  output logic             lamp_on
);
  // key indices
  localparam int K_VIEW = 0, K_QUICK = 1, K_MENU = 2, K_EDIT = 3, K_OK = 4, K_CAN = 5;
  localparam int K_PLUS = 6, K_MINUS = 7, K_LEFT = 8, K_RIGHT = 9, K_HALT = 10, K_JOG = 11;
  localparam int K_START = 12, K_DIR = 13;
  logic [NKEYS+1:0] key_all;
  logic [NKEYS+1:0] key_db;
  logic [NKEYS+1:0] key_prev_q;
  logic [NKEYS+1:0] key_rise;
  logic [NKEYS+1:0] key_fall;
  // start and direction take the two top key bits of an extended bus, tied low here
  assign key_all = {2'b00, key_raw};

  //////////////////////////////////////////////////////////////////////////////
  // debounce: a key must stay stable for DEB_CYC before it counts
  // a bounce restarts the count; long bounces only delay the press
  genvar gi;
  generate
    for (gi = 0; gi < NKEYS + 2; gi++) begin : g_deb
      logic [15:0] cnt_q;
      logic        st_q;
      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          cnt_q <= 16'h0000;
          st_q  <= 1'b0;
        end else if (key_all[gi] == st_q) begin
          cnt_q <= 16'h0000;
        end else if (cnt_q >= 16'(DEB_CYC - 1)) begin
          cnt_q <= 16'h0000; // [RULE21]
          st_q  <= key_all[gi];
        end else begin
          cnt_q <= cnt_q + 16'h0001;
        end
      end
      assign key_db[gi] = st_q;
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) key_prev_q <= '0;
    else       key_prev_q <= key_db;
  end
  assign key_rise = key_db & ~key_prev_q; // [RULE21]
  assign key_fall = ~key_db & key_prev_q;

  //////////////////////////////////////////////////////////////////////////////
  // apb registers
  logic [31:0] ctrl_q;
  logic [31:0] sel_q;
  logic [31:0] edit_q;
  logic [31:0] keys_sw_q;
  wire         wr_en  = psel & penable & pwrite;
  wire         hit_ctrl = paddr == `PKDC_ADDR_CTRL;
  wire         hit_sel  = paddr == `PKDC_ADDR_SEL;
  wire         hit_stat = paddr == `PKDC_ADDR_STAT;
  wire         hit_disp = paddr == `PKDC_ADDR_DISP;
  wire         hit_keys = paddr == `PKDC_ADDR_KEYS;
  wire         hit_cmd  = paddr == `PKDC_ADDR_CMD;
  wire         hit_edit = paddr == `PKDC_ADDR_EDIT;
  wire         hit_any  = hit_ctrl | hit_sel | hit_stat | hit_disp | hit_keys | hit_cmd | hit_edit;
  wire         halt_en  = ctrl_q[`PKDC_CTRL_HALT_EN];
  wire         jog_en   = ctrl_q[`PKDC_CTRL_JOG_EN];
  wire         dir_en   = ctrl_q[`PKDC_CTRL_DIR_EN];
  wire         local_op = ctrl_q[`PKDC_CTRL_LOCAL];
  wire         prog_blk = ctrl_q[`PKDC_CTRL_PROG_BLK];
  wire         dir_perm = ctrl_q[`PKDC_CTRL_DIRPERM];
  wire [1:0]   term_mode = ctrl_q[`PKDC_CTRL_MODE_HI:`PKDC_CTRL_MODE_LO];
  // start and direction keys are reachable only from the keys register (bits 0/1)
  wire         sw_start = wr_en & hit_keys & pwdata[0];
  wire         sw_dir   = wr_en & hit_keys & pwdata[1];

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= `PKDC_CTRL_RST;
      sel_q  <= 32'h0000_0000;
      edit_q <= 32'h0000_0000;
    end else if (wr_en) begin
      if (hit_ctrl) ctrl_q <= pwdata;
      if (hit_sel)  sel_q  <= pwdata;
      if (hit_edit) edit_q <= pwdata;
    end
  end
  assign keys_sw_q = {30'h0, sw_dir, sw_start};
  // every register answers in its access cycle, so no wait states
  assign pready    = 1'b1;
  assign pslverr   = psel & penable & ~hit_any;
  assign setup_act = sel_q[`PKDC_SEL_ACT_HI:`PKDC_SEL_ACT_LO]; // [RULE18]
  assign setup_prg = sel_q[`PKDC_SEL_PRG_HI:`PKDC_SEL_PRG_LO];

  //////////////////////////////////////////////////////////////////////////////
  // view key: short press toggles, hold enters state 3
  logic [31:0] hold_cnt_q;
  logic        view_arm_q;
  wire  view_on   = key_db[K_VIEW];
  wire  hold_hit  = view_on && hold_cnt_q == 32'(HOLD_CYC - 1); // [RULE22]
  wire  in_disp   = mode_q == pkdc_pkg::PKDC_M_DISP;
  // a press that began in a menu only brings display mode back; it must
  // neither toggle the read-out on release nor count as a hold
  wire  view_hold = hold_hit & view_arm_q;
  wire  view_tap  = key_fall[K_VIEW] && view_arm_q && readout_q != pkdc_pkg::PKDC_RO3;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn)                           view_arm_q <= 1'b0;
    else if (key_rise[K_VIEW] & in_disp) view_arm_q <= 1'b1;
    else if (!view_on)                   view_arm_q <= 1'b0;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn)            hold_cnt_q <= 32'h0000_0000;
    else if (!view_on)    hold_cnt_q <= 32'h0000_0000;
    else if (!hold_hit)   hold_cnt_q <= hold_cnt_q + 32'h0000_0001;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      readout_q <= pkdc_pkg::PKDC_RO1; // [RULE3]
    end else if (in_disp) begin
      case (readout_q)
        pkdc_pkg::PKDC_RO1: if (view_hold) readout_q <= pkdc_pkg::PKDC_RO3; // [RULE2]
                            else if (view_tap) readout_q <= pkdc_pkg::PKDC_RO2; // [RULE1]
        pkdc_pkg::PKDC_RO2: if (view_hold) readout_q <= pkdc_pkg::PKDC_RO3;
                            else if (view_tap) readout_q <= pkdc_pkg::PKDC_RO1; // [RULE1]
        pkdc_pkg::PKDC_RO3: if (key_fall[K_VIEW]) readout_q <= pkdc_pkg::PKDC_RO2; // [RULE2]
        default:            readout_q <= pkdc_pkg::PKDC_RO1;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // menu and data-change modes
  // edit is refused outright while programming is blocked
  wire prog_ok = ~prog_blk; // [RULE17]
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      mode_q <= pkdc_pkg::PKDC_M_DISP;
    end else begin
      case (mode_q)
        pkdc_pkg::PKDC_M_DISP:
          if (key_rise[K_QUICK]) mode_q <= pkdc_pkg::PKDC_M_QUICK;
          else if (key_rise[K_MENU]) mode_q <= pkdc_pkg::PKDC_M_MENU;
        pkdc_pkg::PKDC_M_QUICK, pkdc_pkg::PKDC_M_MENU:
          if (key_rise[K_VIEW]) mode_q <= pkdc_pkg::PKDC_M_DISP; // [RULE8]
          else if (key_rise[K_QUICK]) mode_q <= pkdc_pkg::PKDC_M_QUICK; // [RULE8]
          else if (key_rise[K_MENU]) mode_q <= pkdc_pkg::PKDC_M_MENU;
          else if (key_rise[K_EDIT] && prog_ok) mode_q <= pkdc_pkg::PKDC_M_EDIT; // [RULE9]
        pkdc_pkg::PKDC_M_EDIT:
          if (key_rise[K_OK] || key_rise[K_CAN]) mode_q <= pkdc_pkg::PKDC_M_MENU; // [RULE9]
        default: mode_q <= pkdc_pkg::PKDC_M_DISP;
      endcase
    end
  end

  // commit only on confirm; cancel leaves the store untouched
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      commit_stb <= 1'b0;
      commit_val <= 32'h0000_0000;
    end else begin
      commit_stb <= (mode_q == pkdc_pkg::PKDC_M_EDIT) & key_rise[K_OK] & prog_ok; // [RULE9]
      if ((mode_q == pkdc_pkg::PKDC_M_EDIT) & key_rise[K_OK]) commit_val <= edit_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // plus/minus and left/right
  wire in_menu = (mode_q == pkdc_pkg::PKDC_M_QUICK) | (mode_q == pkdc_pkg::PKDC_M_MENU);
  wire in_edit = mode_q == pkdc_pkg::PKDC_M_EDIT;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      var_sel_q   <= 5'h00;
      param_sel_q <= 8'h00;
      group_q     <= 3'h0;
      cursor_q    <= 3'h0;
    end else begin
      if (wr_en & hit_sel) begin
        var_sel_q <= pwdata[`PKDC_SEL_VAR_HI:`PKDC_SEL_VAR_LO]; // [RULE20]
      end else if (in_disp & key_rise[K_PLUS] & var_sel_q != `PKDC_VAR_MAX) begin
        var_sel_q <= var_sel_q + 5'h01; // [RULE4]
      end else if (in_disp & key_rise[K_MINUS] & var_sel_q != 5'h00) begin
        var_sel_q <= var_sel_q - 5'h01; // [RULE10]
      end
      if (in_menu & key_rise[K_PLUS])  param_sel_q <= param_sel_q + 8'h01; // [RULE10]
      if (in_menu & key_rise[K_MINUS]) param_sel_q <= param_sel_q - 8'h01;
      if (in_menu & key_rise[K_RIGHT] & group_q != `PKDC_GROUP_MAX)
        group_q <= group_q + 3'h1; // [RULE10]
      if (in_menu & key_rise[K_LEFT] & group_q != 3'h0)  group_q <= group_q - 3'h1;
      if (in_edit & key_rise[K_RIGHT]) cursor_q <= cursor_q + 3'h1; // [RULE10]
      if (in_edit & key_rise[K_LEFT])  cursor_q <= cursor_q - 3'h1;
      if (!in_edit) cursor_q <= 3'h0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // local run keys
  wire start_ev = key_rise[K_START] | sw_start;
  wire dir_ev   = key_rise[K_DIR] | sw_dir;
  // halt and jog act in local and remote alike; direction only in local
  wire dir_ok   = local_op & dir_en & dir_perm & // [RULE14] [RULE16]
                  (term_mode == 2'h1 || term_mode == 2'h3);
  assign trip_clear = halt_en & key_rise[K_HALT] & alarm_in; // [RULE11]
  // jog stays off while halted so a panel stop cannot be bypassed
  assign jog_active = jog_en & key_db[K_JOG] & ~halt_q; // [RULE13]

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      halt_q    <= 1'b0;
      dir_rev_q <= 1'b0;
    end else begin
      // halt wins a same-cycle start; held regardless of panel presence
      if (halt_en & key_rise[K_HALT] & ~alarm_in) halt_q <= 1'b1; // [RULE11] [RULE12]
      else if (start_ev & ~term_stop) halt_q <= 1'b0; // [RULE15] [RULE12]
      if (dir_ev & dir_ok) dir_rev_q <= ~dir_rev_q; // [RULE14]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // flash timebase
  // one shared blink serves the halt line and the programmed setup
  logic [31:0] flash_cnt_q;
  logic        flash_q;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      flash_cnt_q <= 32'h0000_0000;
      flash_q     <= 1'b0;
    end else if (flash_cnt_q == 32'(FLASH_CYC - 1)) begin
      flash_cnt_q <= 32'h0000_0000;
      flash_q     <= ~flash_q;
    end else begin
      flash_cnt_q <= flash_cnt_q + 32'h0000_0001;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // display line control and lamps
  wire alarm_or_warn = alarm_in | warn_in;
  assign line2_show  = ~alarm_or_warn; // [RULE6] [RULE5]
  assign line2_flash = halt_q & flash_q; // [RULE11]
  assign line3_sel   = in_disp ? pkdc_pkg::PKDC_L3_BLANK : // [RULE7]
                       (mode_q == pkdc_pkg::PKDC_M_MENU ? pkdc_pkg::PKDC_L3_GROUP
                                                         : pkdc_pkg::PKDC_L3_PARAM);
  assign line4_value = ~in_disp; // [RULE7]
  assign unit_letter_u   = ~ctrl_q[`PKDC_CTRL_UNIT_SEL]; // [RULE20]
  assign setup_prg_show  = setup_prg != setup_act; // [RULE18]
  assign setup_prg_blink = setup_prg_show & flash_q;
  assign lamp_alarm = alarm_in; // [RULE19]
  assign lamp_warn  = warn_in;
  assign lamp_on    = power_ok;

  // read mux
  // data is taken in the setup cycle so it stands through the access
  logic [31:0] rd_mux;
  assign rd_mux = hit_ctrl ? ctrl_q :
                  hit_sel  ? sel_q :
                  hit_stat ? {29'h0, term_stop, warn_in, alarm_in} :
                  hit_disp ? {16'h0, 2'h0, line3_sel, mode_q, 1'b0, readout_q, dir_rev_q,
                              halt_q, jog_active, 1'b0} :
                  hit_keys ? {{(32-NKEYS){1'b0}}, key_db[NKEYS-1:0]} :
                  hit_cmd  ? {param_sel_q, 5'h0, group_q, 3'h0, var_sel_q, 5'h0, cursor_q} :
                  hit_edit ? edit_q : 32'h0000_0000;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) prdata <= 32'h0000_0000;
    else if (psel & ~penable & ~pwrite) prdata <= rd_mux;
  end
  logic unused_keys;
  assign unused_keys = ^keys_sw_q;
endmodule // pkdc_top

// file: verif/pkdc_keypad_model.sv
// keypad model: key levels with contact bounce on every press
// assumes the controller clock; drives key_raw only
`timescale 1ns/1ps
module pkdc_keypad_model (
  // clock
  input  wire logic        ref_clk,
  // key levels, high while pressed
  output logic      [11:0] key_raw
);
  initial key_raw = 12'h000;
  // a press bounces once; n of 0 leaves only the lone glitch
  task automatic tap(input int k, input int n);
    @(posedge ref_clk);
    key_raw[k] <= 1'b1;
    @(posedge ref_clk);
    key_raw[k] <= 1'b0;
    if (n > 0) begin
      @(posedge ref_clk);
      key_raw[k] <= 1'b1;
      repeat (n) @(posedge ref_clk);
      key_raw[k] <= 1'b0;
    end
    repeat (12) @(posedge ref_clk);
  endtask
endmodule // pkdc_keypad_model

// file: verif/pkdc_top_sva.sv
// checker for the panel key/display controller outputs
// assumes bind onto pkdc_top; sees only its ports
`timescale 1ns/1ps
`include "pkdc_regs.svh"
module pkdc_top_sva #(
  parameter int HOLD_CYC = 20
) (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [11:0] key_raw,
  input  wire logic        term_stop,
  input  wire logic        alarm_in,
  input  wire logic        warn_in,
  input  wire logic        halt_q,
  input  wire logic        dir_rev_q,
  input  wire logic        commit_stb,
  input  pkdc_pkg::pkdc_ro_t   readout_q,
  input  pkdc_pkg::pkdc_mode_t mode_q,
  input  pkdc_pkg::pkdc_l3_t   line3_sel,
  input  wire logic        line2_show,
  input  wire logic        line2_flash,
  input  wire logic        line4_value,
  input  wire logic        lamp_alarm,
  input  wire logic        lamp_warn
);
  logic [7:0] hold_q;
  wire        keys_wr = psel & penable & pwrite & (paddr == `PKDC_ADDR_KEYS);
  // raw hold length; saturates, so only short thresholds fit
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) hold_q <= 8'h00;
    else if (!key_raw[0]) hold_q <= 8'h00;
    else if (hold_q != 8'hff) hold_q <= hold_q + 8'h01;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////
  property p_ro1_reset;
    $rose(rstn) |-> readout_q == pkdc_pkg::PKDC_RO1;
  endproperty
  a_ro1_reset: assert property (p_ro1_reset) else $error("readout not state 1");
  property p_hold3;
    $rose(readout_q == pkdc_pkg::PKDC_RO3) |-> hold_q >= HOLD_CYC;
  endproperty
  a_hold3: assert property (p_hold3) else $error("state 3 before hold time");
  property p_rel3;
    $fell(readout_q == pkdc_pkg::PKDC_RO3) |-> readout_q == pkdc_pkg::PKDC_RO2;
  endproperty
  a_rel3: assert property (p_rel3) else $error("state 3 left not to 2");
  property p_l2show;
    line2_show == !(alarm_in | warn_in);
  endproperty
  a_l2show: assert property (p_l2show) else $error("line 2 shown wrongly");
  property p_lamps;
    lamp_alarm == alarm_in && lamp_warn == warn_in;
  endproperty
  a_lamps: assert property (p_lamps) else $error("lamp mismatch");
  property p_line3;
    mode_q == pkdc_pkg::PKDC_M_DISP |-> line3_sel == pkdc_pkg::PKDC_L3_BLANK;
  endproperty
  a_line3: assert property (p_line3) else $error("line 3 not blank");
  property p_line4;
    line4_value == (mode_q != pkdc_pkg::PKDC_M_DISP);
  endproperty
  a_line4: assert property (p_line4) else $error("line 4 source wrong");
  property p_commit;
    commit_stb |-> ($past(mode_q) == pkdc_pkg::PKDC_M_EDIT) ##1 !commit_stb;
  endproperty
  a_commit: assert property (p_commit) else $error("commit outside edit");
  property p_flash;
    line2_flash |-> halt_q;
  endproperty
  a_flash: assert property (p_flash) else $error("flash without halt");
  property p_halt_rel;
    $fell(halt_q) |-> $past(keys_wr && pwdata[0] && !term_stop);
  endproperty
  a_halt_rel: assert property (p_halt_rel) else $error("halt left without start");
  property p_dir;
    $changed(dir_rev_q) |-> $past(keys_wr && pwdata[1]);
  endproperty
  a_dir: assert property (p_dir) else $error("direction changed unasked");
endmodule // pkdc_top_sva

bind pkdc_top pkdc_top_sva #(.HOLD_CYC(HOLD_CYC)) u_sva (
  .ref_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .key_raw, .term_stop,
  .alarm_in, .warn_in, .halt_q, .dir_rev_q, .commit_stb, .readout_q, .mode_q,
  .line3_sel, .line2_show, .line2_flash, .line4_value, .lamp_alarm, .lamp_warn
);

// file: verif/pkdc_top_bench.sv
// bench for the panel key/display controller
// assumes keypad model, checker bind and apb master tasks here
`timescale 1ns/1ps
`include "pkdc_regs.svh"
module pkdc_top_bench;
  logic        ref_clk, rstn, psel, penable, pwrite, alarm_in, warn_in, term_stop, power_ok;
  logic [11:0] paddr, key_raw;
  logic [31:0] pwdata, prdata, commit_val, ev;
  logic        pready, pslverr, halt_q, jog_active, dir_rev_q, commit_stb, ex_j, ex_h, ex_d;
  logic        unit_letter_u, setup_prg_show;
  pkdc_pkg::pkdc_ro_t   readout_q, ex_r;
  pkdc_pkg::pkdc_mode_t mode_q, ex_m;
  logic [9:0]  st_q[$], last;
  logic [32:0] rd_q[$];
  logic [31:0] cm_q[$];
  int          error_cnt, cmp_count, cyc, seed, i;
  wire  [9:0]  st_now = {jog_active, halt_q, dir_rev_q, mode_q, readout_q};
  pkdc_keypad_model km (.ref_clk, .key_raw);
  pkdc_top #(.DEB_CYC(2), .HOLD_CYC(20), .FLASH_CYC(4)) uut (
    .ref_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .key_raw, .alarm_in, .warn_in, .term_stop, .power_ok, .halt_q, .trip_clear(),
    .jog_active, .dir_rev_q, .commit_stb, .commit_val, .param_sel_q(), .group_q(),
    .readout_q, .mode_q, .line3_sel(), .line2_show(), .line2_flash(), .line4_value(),
    .unit_letter_u, .var_sel_q(), .cursor_q(), .setup_act(), .setup_prg(),
    .setup_prg_show, .setup_prg_blink(), .lamp_alarm(), .lamp_warn(), .lamp_on()
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [32:0] e, input logic [32:0] o);
    cmp_count++;
    if (e !== o) begin
      error_cnt++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, o);
    end
  endtask
  task automatic nt();
    st_q.push_back({ex_j, ex_h, ex_d, ex_m, ex_r});
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    rd_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  // view taps: note the read-out expected, then press
  task automatic vk(input pkdc_pkg::pkdc_ro_t r, input int n);
    ex_r = r;
    nt();
    km.tap(0, n);
  endtask
  task automatic mk(input pkdc_pkg::pkdc_mode_t m, input int k);
    ex_m = m;
    nt();
    km.tap(k, 6);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // monitor: every state change or read answer takes the oldest note
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      test_done();
    end
    if (rstn && st_now !== last) begin
      last = st_now;
      chk(st_q.size() ? st_q.pop_front() : 'x, last);
    end
    if (psel && penable && !pwrite && pready === 1'b1)
      chk(rd_q.size() ? rd_q.pop_front() : 'x, {pslverr, prdata});
    if (commit_stb === 1'b1) chk(cm_q.size() ? cm_q.pop_front() : 'x, commit_val);
  end
  initial begin
    {rstn, psel, penable, pwrite, alarm_in, warn_in, term_stop, ex_j, ex_h, ex_d} = '0;
    power_ok = 1'b1;
    paddr    = 12'h000;
    pwdata   = 32'h0;
    seed     = 79398;
    ex_m     = pkdc_pkg::PKDC_M_DISP;
    ex_r     = pkdc_pkg::PKDC_RO1;
    last     = 10'h009;
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(`PKDC_ADDR_CTRL, {1'b0, `PKDC_CTRL_RST});
    apb(1'b1, 12'h0fc, $random(seed));
    rd(12'h0fc, 33'h1_0000_0000);
    $display("test registers done");
    km.tap(0, 0);
    vk(pkdc_pkg::PKDC_RO2, 6);
    vk(pkdc_pkg::PKDC_RO1, 6);
    vk(pkdc_pkg::PKDC_RO2, 12);
    ex_r = pkdc_pkg::PKDC_RO3;
    nt();
    vk(pkdc_pkg::PKDC_RO2, 40);
    vk(pkdc_pkg::PKDC_RO1, 6);
    $display("test read-out done");
    mk(pkdc_pkg::PKDC_M_QUICK, 1);
    mk(pkdc_pkg::PKDC_M_MENU, 2);
    mk(pkdc_pkg::PKDC_M_QUICK, 1);
    ev = $random(seed);
    apb(1'b1, `PKDC_ADDR_EDIT, ev);
    mk(pkdc_pkg::PKDC_M_EDIT, 3);
    cm_q.push_back(ev);
    mk(pkdc_pkg::PKDC_M_MENU, 4);
    mk(pkdc_pkg::PKDC_M_EDIT, 3);
    mk(pkdc_pkg::PKDC_M_MENU, 5);
    km.tap(9, 6);
    km.tap(6, 6);
    apb(1'b1, `PKDC_ADDR_CTRL, 32'h17);
    km.tap(3, 6);
    apb(1'b1, `PKDC_ADDR_CTRL, `PKDC_CTRL_RST);
    mk(pkdc_pkg::PKDC_M_DISP, 0);
    km.tap(6, 6);
    km.tap(6, 6);
    km.tap(7, 6);
    rd(`PKDC_ADDR_CMD, 33'h0_0101_0100);
    $display("test menus done");
    ex_h = 1'b1;
    nt();
    km.tap(10, 6);
    term_stop <= 1'b1;
    apb(1'b1, `PKDC_ADDR_KEYS, 32'h1);
    term_stop <= 1'b0;
    ex_h = 1'b0;
    nt();
    apb(1'b1, `PKDC_ADDR_KEYS, 32'h1);
    apb(1'b1, `PKDC_ADDR_CTRL, 32'h6);
    km.tap(10, 6);
    ex_j = 1'b1;
    nt();
    ex_j = 1'b0;
    nt();
    km.tap(11, 20);
    apb(1'b1, `PKDC_ADDR_CTRL, 32'h5);
    km.tap(11, 20);
    $display("test run keys done");
    for (i = 0; i < 4; i++) begin
      apb(1'b1, `PKDC_ADDR_CTRL, 32'h2f | (32'(i) << 8));
      if (i == 1 || i == 3) begin
        ex_d = ~ex_d;
        nt();
      end
      apb(1'b1, `PKDC_ADDR_KEYS, 32'h2);
    end
    apb(1'b1, `PKDC_ADDR_CTRL, 32'h127);
    apb(1'b1, `PKDC_ADDR_KEYS, 32'h2);
    apb(1'b1, `PKDC_ADDR_CTRL, 32'h10f);
    apb(1'b1, `PKDC_ADDR_KEYS, 32'h2);
    apb(1'b1, `PKDC_ADDR_SEL, 32'h9);
    @(posedge ref_clk);
    chk(33'h3, 33'({unit_letter_u, setup_prg_show}));
    apb(1'b1, `PKDC_ADDR_CTRL, 32'h47);
    apb(1'b1, `PKDC_ADDR_SEL, 32'ha);
    @(posedge ref_clk);
    chk(33'h0, 33'({unit_letter_u, setup_prg_show}));
    $display("test direction done");
    for (i = 0; i < 16; i++) begin
      {power_ok, warn_in, alarm_in} <= 3'($random(seed));
      @(posedge ref_clk);
    end
    $display("test status done");
    repeat (20) @(posedge ref_clk);
    chk(33'h0, 33'(st_q.size() + rd_q.size() + cm_q.size()));
    test_done();
  end
endmodule // pkdc_top_bench
